// ===== rtc_core_defines.vh
// Constants for the real-time clock core: map, fields, reset values, timing
`ifndef RTC_CORE_DEFINES_VH
`define RTC_CORE_DEFINES_VH
// Byte addresses of the clock bytes and the control/status registers
`define ADDR_SEC 7'h00
`define ADDR_SEC_ALM 7'h01
`define ADDR_MIN 7'h02
`define ADDR_MIN_ALM 7'h03
`define ADDR_HR 7'h04
`define ADDR_HR_ALM 7'h05
`define ADDR_DOW 7'h06
`define ADDR_DATE 7'h07
`define ADDR_MON 7'h08
`define ADDR_YEAR 7'h09
`define ADDR_REG_A 7'h0a
`define ADDR_REG_B 7'h0b
`define ADDR_REG_C 7'h0c
`define ADDR_REG_D 7'h0d
// Register A fields
`define A_UPDATE_PENDING 7
`define A_DIV_HI 6
`define A_DIV_LO 4
`define A_RATE_HI 3
`define A_RATE_LO 0
// Register B fields
`define B_TRANSFER_FREEZE 7
`define B_PERIODIC_EN 6
`define B_ALARM_EN 5
`define B_UPDATE_EN 4
`define B_SQUARE_WAVE_EN 3
`define B_NUMBER_FORMAT 2
`define B_HOUR_FORMAT 1
// Register C fields
`define C_IRQ_REQUEST 7
`define C_PERIODIC_FLAG 6
`define C_ALARM_FLAG 5
`define C_UPDATE_DONE 4
`define C_FAST_CLOCK_EN 0
// Reset values
`define REG_A_RESET 7'h00
`define REG_B_RESET 8'h00
// Divider control codes
`define DIV_RUN 3'h2
`define DIV_RUN_C_WR 3'h3
`define DIV_HOLD_HI 2'h3
// Oscillator and update timing
`define OSC_HZ 32768
`define PRE_UPDATE_WINDOW_US 244
`define PRE_UPDATE_TICKS ((`PRE_UPDATE_WINDOW_US * `OSC_HZ + 999999) / 1000000)
`define DIV_TOP 15'h7fff
`endif

// ===== rtc_host_port_update_core.v
// Real-time clock core: host port, update cycle, divider, square wave, interrupt
//
// Behaviour
// - Address phase, then bidirectional data phase
// - Address strobe falling edge captures address
// - Address capture ignores chip select
// - Style input picks strobe style, default low
// - Separate style: read strobe fall enables outputs
// - Separate style: write strobe rise captures data
// - Strobe style: drive read data after rise
// - Strobe style: data strobe fall captures write
// - Strobe style: direction level selects read/write
// - Interrupt pulls low on enabled set flag; update flag only while not frozen
// - Reading register C releases interrupt
// - Reset releases interrupt, blocks access, clears control
// - Square wave low unless enabled, selected tap
// - Raw oscillator out on 011 plus enables
// - RAM enable follows input when power valid
// - Fourteen register bytes, 114 storage bytes
// - Update cycle each second advances calendar
// - Freeze holds user copy, internal advances
// - Pending bit leads update, done flag ends
// - Host sets time under freeze, then releases
// - Divider to 1 Hz, taps into rate mux
// - Rate code maps to tap period
// - Register C read clears all flags
// - Divider control runs, holds or stops oscillator
`timescale 1ns/1ns
`include "rtc_core_defines.vh"
module rtc_host_port_update_core (
  input wire clk,
  input wire arst_n,
  input wire osc_clk_in,
  input wire power_valid,
  input wire bus_style_select,
  input wire chip_select_n,
  input wire address_strobe,
  input wire data_strobe,
  input wire read_write,
  input wire [7:0] mux_bus_lines_in,
  output reg [7:0] mux_bus_lines_out,
  output reg mux_bus_lines_oe,
  output wire irq_n_out,
  output wire irq_n_oe,
  output reg square_wave_out,
  input wire ram_enable_in_n,
  output wire ram_enable_out_n
);
  localparam ST_IDLE = 2'h0;
  localparam ST_PEND = 2'h1;
  localparam ST_UPD = 2'h2;
  localparam ST_XFER = 2'h3;

  reg rst_s1_r, rst_n_s_r;
  reg as_d_r, ds_d_r, rw_d_r, osc_d_r, tap_d_r;
  reg [6:0] addr_r;
  reg [7:0] ram [0:127];
  reg [6:0] a_r;
  reg [7:0] b_r;
  reg pf_r, af_r, uf_r, fast_en_r, freeze_d_r;
  reg [14:0] cnt_r;
  reg [1:0] st_r;
  reg [7:0] l_sec_r, l_min_r, l_hr_r, l_dow_r, l_date_r, l_mon_r, l_yr_r;
  reg [7:0] rd_mux;
  reg [7:0] adv_sec, adv_min, adv_hr, adv_dow, adv_date, adv_mon, adv_yr;
  reg [7:0] s, m, h, w, d, mo, y, hb;
  reg cy, pm;

  wire [31:0] pre_ticks = `PRE_UPDATE_TICKS;
  wire [14:0] uip_point = `DIV_TOP - pre_ticks[14:0] + 15'h0001;
  wire [2:0] div_ctl = a_r[`A_DIV_HI:`A_DIV_LO];
  wire [3:0] rate_sel = a_r[`A_RATE_HI:`A_RATE_LO];
  wire div_run = (div_ctl == `DIV_RUN) || (div_ctl == `DIV_RUN_C_WR);
  wire div_hold = (div_ctl[2:1] == `DIV_HOLD_HI);
  wire osc_on = div_run | div_hold;
  wire tick = osc_clk_in & ~osc_d_r;
  wire freeze = b_r[`B_TRANSFER_FREEZE];
  wire num_bin = b_r[`B_NUMBER_FORMAT];
  wire h24 = b_r[`B_HOUR_FORMAT];
  wire update_pending = (st_r != ST_IDLE);

  // Bus strobe decode for both styles
  wire as_fall = as_d_r & ~address_strobe;
  wire ds_fall = ds_d_r & ~data_strobe;
  wire ds_rise = ~ds_d_r & data_strobe;
  wire rw_rise = ~rw_d_r & read_write;
  wire cs_on = ~chip_select_n;
  wire rd_start = cs_on & (bus_style_select ? (ds_rise & read_write) : ds_fall);
  wire rd_hold = cs_on & (bus_style_select ? (data_strobe & read_write) : ~data_strobe);
  wire wr_go = cs_on & (bus_style_select ? (ds_fall & ~read_write) : rw_rise);
  wire ctl_addr = (addr_r >= `ADDR_REG_A) && (addr_r <= `ADDR_REG_D);
  wire wr_ram = wr_go & ~ctl_addr;
  wire rd_c = rd_start && (addr_r == `ADDR_REG_C);

  // Interrupt request and open-drain pin
  wire irq_req = (pf_r & b_r[`B_PERIODIC_EN]) | (af_r & b_r[`B_ALARM_EN]) |
                 (uf_r & b_r[`B_UPDATE_EN] & ~freeze);
  assign irq_n_out = 1'b0;
  assign irq_n_oe = irq_req & rst_n_s_r;

  // RAM chip enable forced inactive without valid power
  assign ram_enable_out_n = power_valid ? ram_enable_in_n : 1'b1;

  // BCD or binary to binary
  function [7:0] to_bin;
    input [7:0] v;
    input bin_mode;
    begin
      to_bin = bin_mode ? v : ({4'h0, v[7:4]} * 8'h0a + {4'h0, v[3:0]});
    end
  endfunction

  // Binary to the selected format
  function [7:0] from_bin;
    input [7:0] v;
    input bin_mode;
    reg [7:0] q;
    reg [7:0] r;
    begin
      q = v / 8'h0a;
      r = v - q * 8'h0a;
      from_bin = bin_mode ? v : {q[3:0], r[3:0]};
    end
  endfunction

  // Days in a month, binary month and year
  function [7:0] month_days;
    input [7:0] mon;
    input [7:0] yr;
    begin
      case (mon)
        8'h02: month_days = (yr[1:0] == 2'h0) ? 8'h1d : 8'h1c;
        8'h04, 8'h06, 8'h09, 8'h0b: month_days = 8'h1e;
        default: month_days = 8'h1f;
      endcase
    end
  endfunction

  // Divider bit for a rate code; codes 1 and 2 alias codes 8 and 9
  function [3:0] tap_index;
    input [3:0] rs;
    begin
      case (rs)
        4'h1: tap_index = 4'h6;
        4'h2: tap_index = 4'h7;
        default: tap_index = rs - 4'h2;
      endcase
    end
  endfunction

  wire rate_on = (rate_sel != 4'h0);
  wire tap = rate_on & cnt_r[tap_index(rate_sel)];

  // Reset release through two flip-flops
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1_r <= 1'b0;
      rst_n_s_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_s_r <= rst_s1_r;
    end
  end

  // Strobe history, address latch and read drive
  always @(posedge clk or negedge rst_n_s_r) begin
    if (!rst_n_s_r) begin
      as_d_r <= 1'b0;
      ds_d_r <= 1'b1;
      rw_d_r <= 1'b1;
      addr_r <= 7'h00;
      mux_bus_lines_out <= 8'h00;
      mux_bus_lines_oe <= 1'b0;
    end else begin
      as_d_r <= address_strobe;
      ds_d_r <= data_strobe;
      rw_d_r <= read_write;
      if (as_fall)
        addr_r <= mux_bus_lines_in[6:0];
      if (rd_start)
        mux_bus_lines_out <= rd_mux;
      mux_bus_lines_oe <= rd_start | (mux_bus_lines_oe & rd_hold);
    end
  end

  // Read data selection
  always @* begin
    case (addr_r)
      `ADDR_REG_A: rd_mux = {update_pending, a_r};
      `ADDR_REG_B: rd_mux = b_r;
      `ADDR_REG_C: rd_mux = {irq_req, pf_r, af_r, uf_r, 3'h0, fast_en_r};
      `ADDR_REG_D: rd_mux = {power_valid, 7'h00};
      default: rd_mux = ram[addr_r];
    endcase
  end

  // Control registers, flags; a set beats a clearing read
  always @(posedge clk or negedge rst_n_s_r) begin
    if (!rst_n_s_r) begin
      a_r <= `REG_A_RESET;
      b_r <= `REG_B_RESET;
      pf_r <= 1'b0;
      af_r <= 1'b0;
      uf_r <= 1'b0;
      fast_en_r <= 1'b0;
      tap_d_r <= 1'b0;
    end else begin
      tap_d_r <= tap;
      if (wr_go && addr_r == `ADDR_REG_A)
        a_r <= mux_bus_lines_in[6:0];
      if (wr_go && addr_r == `ADDR_REG_B)
        b_r <= mux_bus_lines_in;
      if (wr_go && addr_r == `ADDR_REG_C && div_ctl == `DIV_RUN_C_WR)
        fast_en_r <= mux_bus_lines_in[`C_FAST_CLOCK_EN];
      if (rd_c) begin
        pf_r <= 1'b0;
        af_r <= 1'b0;
        uf_r <= 1'b0;
      end
      if (tap_d_r & ~tap)
        pf_r <= 1'b1;
      if (st_r == ST_XFER) begin
        uf_r <= 1'b1;
        if ((ram[`ADDR_SEC_ALM][7:6] == 2'h3 || ram[`ADDR_SEC_ALM] == l_sec_r) &&
            (ram[`ADDR_MIN_ALM][7:6] == 2'h3 || ram[`ADDR_MIN_ALM] == l_min_r) &&
            (ram[`ADDR_HR_ALM][7:6] == 2'h3 || ram[`ADDR_HR_ALM] == l_hr_r))
          af_r <= 1'b1;
      end
    end
  end

  // Oscillator divider and update sequence
  always @(posedge clk or negedge rst_n_s_r) begin
    if (!rst_n_s_r) begin
      osc_d_r <= 1'b0;
      cnt_r <= 15'h0000;
      st_r <= ST_IDLE;
    end else begin
      osc_d_r <= osc_clk_in;
      if (div_hold)
        cnt_r <= 15'h0000;
      else if (div_run && tick)
        cnt_r <= cnt_r + 15'h0001;
      case (st_r)
        ST_IDLE: begin
          if (div_run && cnt_r >= uip_point)
            st_r <= ST_PEND;
        end
        ST_PEND: begin
          if (!div_run)
            st_r <= ST_IDLE;
          else if (tick && cnt_r == `DIV_TOP)
            st_r <= ST_UPD;
        end
        ST_UPD: st_r <= ST_XFER;
        ST_XFER: st_r <= ST_IDLE;
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  // Next calendar value, worked in binary
  always @* begin
    s = to_bin(l_sec_r, num_bin) + 8'h01;
    cy = (s >= 8'h3c);
    if (cy)
      s = 8'h00;
    m = to_bin(l_min_r, num_bin);
    if (cy) begin
      m = m + 8'h01;
      cy = (m >= 8'h3c);
      if (cy)
        m = 8'h00;
    end
    pm = l_hr_r[7] & ~h24;
    h = to_bin(h24 ? l_hr_r : {1'b0, l_hr_r[6:0]}, num_bin);
    if (cy) begin
      if (h24) begin
        h = h + 8'h01;
        cy = (h >= 8'h18);
        if (cy)
          h = 8'h00;
      end else begin
        cy = 1'b0;
        if (h == 8'h0c)
          h = 8'h01;
        else begin
          h = h + 8'h01;
          if (h == 8'h0c) begin
            cy = pm;
            pm = ~pm;
          end
        end
      end
    end
    w = to_bin(l_dow_r, num_bin);
    d = to_bin(l_date_r, num_bin);
    mo = to_bin(l_mon_r, num_bin);
    y = to_bin(l_yr_r, num_bin);
    if (cy) begin
      w = (w >= 8'h07) ? 8'h01 : w + 8'h01;
      if (d >= month_days(mo, y)) begin
        d = 8'h01;
        if (mo >= 8'h0c) begin
          mo = 8'h01;
          y = (y >= 8'h63) ? 8'h00 : y + 8'h01;
        end else
          mo = mo + 8'h01;
      end else
        d = d + 8'h01;
    end
    hb = from_bin(h, num_bin);
    adv_sec = from_bin(s, num_bin);
    adv_min = from_bin(m, num_bin);
    adv_hr = h24 ? hb : {pm, hb[6:0]};
    adv_dow = from_bin(w, num_bin);
    adv_date = from_bin(d, num_bin);
    adv_mon = from_bin(mo, num_bin);
    adv_yr = from_bin(y, num_bin);
  end

  // Internal time copy: loads host values when freeze drops, else advances
  always @(posedge clk or negedge rst_n_s_r) begin
    if (!rst_n_s_r) begin
      freeze_d_r <= 1'b0;
      l_sec_r <= 8'h00;
      l_min_r <= 8'h00;
      l_hr_r <= 8'h00;
      l_dow_r <= 8'h01;
      l_date_r <= 8'h01;
      l_mon_r <= 8'h01;
      l_yr_r <= 8'h00;
    end else begin
      freeze_d_r <= freeze;
      if (freeze_d_r && !freeze) begin
        l_sec_r <= ram[`ADDR_SEC];
        l_min_r <= ram[`ADDR_MIN];
        l_hr_r <= ram[`ADDR_HR];
        l_dow_r <= ram[`ADDR_DOW];
        l_date_r <= ram[`ADDR_DATE];
        l_mon_r <= ram[`ADDR_MON];
        l_yr_r <= ram[`ADDR_YEAR];
      end else if (st_r == ST_UPD) begin
        l_sec_r <= adv_sec;
        l_min_r <= adv_min;
        l_hr_r <= adv_hr;
        l_dow_r <= adv_dow;
        l_date_r <= adv_date;
        l_mon_r <= adv_mon;
        l_yr_r <= adv_yr;
      end
    end
  end

  // User copy and storage; a host write placed last wins over the transfer
  always @(posedge clk) begin
    if (st_r == ST_XFER && !freeze) begin
      ram[`ADDR_SEC] <= l_sec_r;
      ram[`ADDR_MIN] <= l_min_r;
      ram[`ADDR_HR] <= l_hr_r;
      ram[`ADDR_DOW] <= l_dow_r;
      ram[`ADDR_DATE] <= l_date_r;
      ram[`ADDR_MON] <= l_mon_r;
      ram[`ADDR_YEAR] <= l_yr_r;
    end
    if (rst_n_s_r && wr_ram)
      ram[addr_r] <= mux_bus_lines_in;
  end

  // Square-wave pin: low when disabled, raw oscillator or rate tap
  always @(posedge clk or negedge rst_n_s_r) begin
    if (!rst_n_s_r)
      square_wave_out <= 1'b0;
    else if (!b_r[`B_SQUARE_WAVE_EN])
      square_wave_out <= 1'b0;
    else if (div_ctl == `DIV_RUN_C_WR && fast_en_r)
      square_wave_out <= osc_clk_in & osc_on;
    else
      square_wave_out <= tap;
  end
endmodule

// ===== rtc_core_checker_properties.sv
// Port checker for the real-time clock core
`timescale 1ns/1ns
`include "rtc_core_defines.vh"
module rtc_core_checker (
  input wire clk,
  input wire arst_n,
  input wire power_valid,
  input wire bus_style_select,
  input wire chip_select_n,
  input wire address_strobe,
  input wire data_strobe,
  input wire read_write,
  input wire [7:0] mux_bus_lines_in,
  input wire [7:0] mux_bus_lines_out,
  input wire mux_bus_lines_oe,
  input wire irq_n_out,
  input wire irq_n_oe,
  input wire square_wave_out,
  input wire ram_enable_in_n,
  input wire ram_enable_out_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  reg as_q_r;
  reg [6:0] addr_r;
  // Shadow of the address taken on the strobe fall
  always @(posedge clk) begin
    as_q_r <= address_strobe;
    if (as_q_r && !address_strobe)
      addr_r <= mux_bus_lines_in[6:0];
  end
  chk_ram_follow: assert property (power_valid |-> ram_enable_out_n == ram_enable_in_n)
    else $error("ram enable not passed through");
  chk_ram_block: assert property (!power_valid |-> ram_enable_out_n)
    else $error("ram enable not blocked");
  chk_reset_quiet: assert property (disable iff (1'b0) !arst_n |-> !mux_bus_lines_oe && !irq_n_oe)
    else $error("outputs active in reset");
  chk_irq_drain: assert property (!irq_n_out)
    else $error("interrupt pin level not low");
  chk_oe_cause: assert property ($rose(mux_bus_lines_oe) |-> $past(!chip_select_n)
    && $past(bus_style_select ? data_strobe && read_write : !data_strobe))
    else $error("bus driven without read strobe");
  chk_oe_drop: assert property (chip_select_n [*3] |-> !mux_bus_lines_oe)
    else $error("bus still driven when deselected");
  chk_data_hold: assert property (mux_bus_lines_oe && $past(mux_bus_lines_oe) |-> $stable(mux_bus_lines_out))
    else $error("read data moved while driven");
  chk_rdc_release: assert property (addr_r == `ADDR_REG_C && !chip_select_n
    && (bus_style_select ? $rose(data_strobe) && read_write : $fell(data_strobe)) |-> ##[1:3] !irq_n_oe)
    else $error("interrupt kept after status read");
  cover property ($rose(mux_bus_lines_oe) && bus_style_select);
  cover property ($rose(mux_bus_lines_oe) && !bus_style_select);
  cover property ($fell(irq_n_oe));
endmodule
bind rtc_host_port_update_core rtc_core_checker chk_u (.clk, .arst_n, .power_valid, .bus_style_select,
  .chip_select_n, .address_strobe, .data_strobe, .read_write, .mux_bus_lines_in, .mux_bus_lines_out,
  .mux_bus_lines_oe, .irq_n_out, .irq_n_oe, .square_wave_out, .ram_enable_in_n, .ram_enable_out_n);

// ===== rtc_host_model.sv
// Host processor model on the multiplexed bus
`timescale 1ns/1ns
module rtc_host_model (
  input wire clk,
  input wire style,
  input wire [7:0] dev_out,
  input wire dev_oe,
  output reg cs_n,
  output reg astb,
  output reg dstb,
  output reg rw,
  output wire [7:0] bus
);
  reg [7:0] drv_r = 8'h00;
  reg drv_en_r = 1'b0;
  // Shared lines: device data, host data, else last value inverted
  assign bus = dev_oe ? dev_out : (drv_en_r ? drv_r : ~drv_r);
  // Idle levels
  initial begin
    cs_n = 1'b1;
    astb = 1'b0;
    dstb = 1'b1;
    rw = 1'b1;
  end
  // Address phase, then one data phase in the selected style
  task xfer(input wr, input [6:0] a, input [7:0] d, output [7:0] q);
    begin
      @(negedge clk);
      astb = 1'b1;
      dstb = ~style;
      drv_r = {1'b0, a};
      drv_en_r = 1'b1;
      @(negedge clk);
      astb = 1'b0;
      @(negedge clk);
      cs_n = 1'b0;
      rw = ~(style & wr);
      dstb = style ? wr : 1'b1;
      drv_r = d;
      drv_en_r = wr;
      @(negedge clk);
      if (style)
        dstb = ~wr;
      else if (wr)
        rw = 1'b0;
      else
        dstb = 1'b0;
      @(negedge clk);
      rw = 1'b1;
      repeat (2) @(negedge clk);
      q = dev_out;
      dstb = ~style;
      @(negedge clk);
      cs_n = 1'b1;
      drv_en_r = 1'b0;
    end
  endtask
endmodule

// ===== tb.sv
// Self-checking bench for the real-time clock core
`timescale 1ns/1ns
module tb;
  reg clk;
  reg arst_n;
  reg osc;
  reg osc_run;
  reg power_valid;
  reg style;
  reg ram_in_n;
  reg osc_fast;
  wire cs_n, astb, dstb, rw, oe, irq_out, irq_oe, sq, ram_out_n;
  wire [7:0] bus;
  wire [7:0] dout;
  reg [7:0] q;
  reg [16:0] rows [0:12];
  integer bad_count;
  integer n_tests;
  integer cyc;
  integer i;
  integer k;
  // Time bytes 0..9 to load: 23:59:59, alarms don't care, day 7, 31 Dec, year 99
  localparam [79:0] time_set = 80'h630c1f07c017c03bc03b;
  // Same bytes after one update: midnight, day 1, 1 Jan, year 0
  localparam [79:0] time_exp = 80'h00010101c000c000c000;
  rtc_host_port_update_core dut_u (.clk(clk), .arst_n(arst_n), .osc_clk_in(osc), .power_valid(power_valid),
    .bus_style_select(style), .chip_select_n(cs_n), .address_strobe(astb), .data_strobe(dstb), .read_write(rw),
    .mux_bus_lines_in(bus), .mux_bus_lines_out(dout), .mux_bus_lines_oe(oe), .irq_n_out(irq_out),
    .irq_n_oe(irq_oe), .square_wave_out(sq), .ram_enable_in_n(ram_in_n), .ram_enable_out_n(ram_out_n));
  rtc_host_model host_u (.clk(clk), .style(style), .dev_out(dout), .dev_oe(oe), .cs_n(cs_n), .astb(astb),
    .dstb(dstb), .rw(rw), .bus(bus));
  // Clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Oscillator toggles every two cycles while running, every cycle when fast
  always begin
    @(negedge clk);
    if (!osc_fast)
      @(negedge clk);
    if (osc_run)
      osc <= ~osc;
  end
  // Hang guard
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 90000) begin
      bad_count = bad_count + 1;
      give_verdict;
    end
  end
  task check(input string what, input [7:0] exp, input [7:0] got);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("FAIL %s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  task acc(input s, input w, input [6:0] a, input [7:0] d);
    begin
      @(negedge clk);
      style = s;
      host_u.xfer(w, a, d, q);
    end
  endtask
  // Counts high cycles of the square wave over 64 cycles
  task hi64;
    begin
      q = 8'h00;
      repeat (64) begin
        @(negedge clk);
        q = q + {7'h00, sq};
      end
    end
  endtask
  task give_verdict;
    begin
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  // Main sequence: rows are {style, write, address, data or expected}
  initial begin
    arst_n = 1'b0;
    osc = 1'b0;
    osc_run = 1'b0;
    osc_fast = 1'b0;
    power_valid = 1'b1;
    style = 1'b0;
    ram_in_n = 1'b1;
    bad_count = 0;
    n_tests = 0;
    cyc = 0;
    rows[0] = 17'h00b00;
    rows[1] = 17'h00a00;
    rows[2] = 17'h0a05a;
    rows[3] = 17'h0205a;
    rows[4] = 17'h1ffc3;
    rows[5] = 17'h17fc3;
    rows[6] = 17'h10d80;
    rows[7] = 17'h08d11;
    rows[8] = 17'h00d80;
    rows[9] = 17'h18b06;
    rows[10] = 17'h00b06;
    rows[11] = 17'h18c01;
    rows[12] = 17'h10c00;
    repeat (12) @(negedge clk);
    check("rst", 8'h00, {6'h00, oe, irq_oe});
    arst_n = 1'b1;
    repeat (4) @(negedge clk);
    for (i = 0; i < 13; i = i + 1) begin
      acc(rows[i][16], rows[i][15], rows[i][14:8], rows[i][7:0]);
      if (!rows[i][15])
        check("row", rows[i][7:0], q);
    end
    arst_n = 1'b0;
    repeat (2) @(negedge clk);
    arst_n = 1'b1;
    repeat (4) @(negedge clk);
    acc(1'b1, 1'b0, 7'h0b, 8'h00);
    check("regb", 8'h00, q);
    acc(1'b1, 1'b1, 7'h0b, 8'h40);
    acc(1'b1, 1'b1, 7'h0a, 8'h23);
    osc_run = 1'b1;
    for (k = 0; k < 200 && irq_oe !== 1'b1; k = k + 1)
      @(negedge clk);
    check("irq", 8'h01, {7'h00, irq_oe});
    acc(1'b1, 1'b1, 7'h0a, 8'h63);
    osc_run = 1'b0;
    acc(1'b0, 1'b0, 7'h0c, 8'h00);
    check("flags", 8'hc0, q & 8'hc0);
    check("irqrel", 8'h00, {7'h00, irq_oe});
    acc(1'b0, 1'b0, 7'h0c, 8'h00);
    check("regc", 8'h00, q);
    acc(1'b0, 1'b1, 7'h0a, 8'h30);
    acc(1'b0, 1'b1, 7'h0c, 8'h01);
    acc(1'b0, 1'b1, 7'h0b, 8'h08);
    for (k = 0; k < 2; k = k + 1) begin
      osc = ~k[0];
      repeat (3) @(negedge clk);
      check("raw", {7'h00, ~k[0]}, {7'h00, sq});
    end
    acc(1'b0, 1'b1, 7'h0c, 8'h00);
    acc(1'b0, 1'b1, 7'h0a, 8'h23);
    osc_run = 1'b1;
    repeat (8) @(negedge clk);
    hi64;
    check("sqw", 8'h20, q);
    acc(1'b0, 1'b1, 7'h0b, 8'h00);
    hi64;
    check("sqoff", 8'h00, q);
    for (k = 0; k < 4; k = k + 1) begin
      power_valid = k[1];
      ram_in_n = k[0];
      @(negedge clk);
      check("ram", {7'h00, k[1] ? k[0] : 1'b1}, {7'h00, ram_out_n});
    end
    // Set the time under freeze, then let one update cycle roll every clock byte over, alarm bytes kept
    osc_fast = 1'b1;
    acc(1'b0, 1'b1, 7'h0b, 8'h86);
    for (k = 0; k < 10; k = k + 1)
      acc(1'b0, 1'b1, k[6:0], time_set[k*8 +: 8]);
    acc(1'b0, 1'b1, 7'h0b, 8'h16);
    q = 8'h00;
    for (k = 0; k < 8000 && q[7] !== 1'b1; k = k + 1)
      acc(1'b0, 1'b0, 7'h0a, 8'h00);
    check("pend", 8'ha3, q);
    for (k = 0; k < 100 && irq_oe !== 1'b1; k = k + 1)
      @(negedge clk);
    check("uirq", 8'h01, {7'h00, irq_oe});
    acc(1'b0, 1'b0, 7'h0c, 8'h00);
    check("uflags", 8'hb0, q & 8'hb0);
    acc(1'b0, 1'b0, 7'h0a, 8'h00);
    check("upend", 8'h23, q);
    for (k = 0; k < 10; k = k + 1) begin
      acc(1'b0, 1'b0, k[6:0], 8'h00);
      check("time", time_exp[k*8 +: 8], q);
    end
    give_verdict;
  end
endmodule
